// ### pkg/bmac_pkg.sv
// Constants used by the multiply-accumulate datapath; its Booth step uses none of them.
// Assumes the register file presents operand values as 32-bit words and
// that the status bits sit inside the program counter word.
package bmac_pkg;

  // Datapath widths.
  localparam int DATA_W = 32;
  localparam int REG_IDX_W = 4;
  localparam int SHAMT_W = 5;
  localparam int STEP_CNT_W = 4;

  // Booth recoding consumes two multiplier bits per step.
  localparam int BOOTH_BITS = 2;
  localparam int BOOTH_STEPS = DATA_W / BOOTH_BITS;
  localparam logic [STEP_CNT_W-1:0] LAST_STEP = 4'hf;

  // Register index of the program counter register.
  localparam logic [REG_IDX_W-1:0] PC_REG_IDX = 4'hf;

  // Split of the program counter register into address and status bits.
  localparam logic [DATA_W-1:0] PC_FIELD_MASK = 32'h03fffffc;
  localparam logic [DATA_W-1:0] STATUS_FIELD_MASK = 32'hfc000003;

  // Prefetch offsets seen when the program counter register is an operand.
  localparam logic [DATA_W-1:0] MULTIPLIER_PC_OFFSET = 32'h00000008;
  localparam logic [DATA_W-1:0] ADDEND_PC_OFFSET = 32'h00000008;
  localparam logic [DATA_W-1:0] MULTIPLICAND_PC_OFFSET = 32'h0000000c;

  // Flag positions inside the status bits, and the sign bit of the result.
  localparam int FLAG_N_POS = 31;
  localparam int FLAG_V_POS = 28;
  localparam int RESULT_SIGN_POS = 31;

  // Reset values.
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
  localparam logic [REG_IDX_W-1:0] IDX_RESET = 4'h0;
  localparam logic [STEP_CNT_W-1:0] STEP_RESET = 4'h0;

  // Sequencer states.
  typedef enum logic [1:0] {
    BMAC_IDLE,
    BMAC_RUN
  } bmac_state_t;

endpackage : bmac_pkg

// ### pkg/bmac_step_if.sv
// Carrier between the sequencer and one Booth recoding step.
// Assumes both ends sit in the same clock domain; the step is combinational.
`timescale 1ns/10ps
interface bmac_step_if;
  logic [31:0] acc;
  logic [31:0] mcand;
  logic [2:0] window;
  logic [4:0] shamt;
  logic [31:0] sum;

  // The sequencer supplies operands and takes back the new partial sum.
  modport seq (output acc, output mcand, output window, output shamt, input sum);

  // The step adds the recoded multiple of the multiplicand.
  modport step (input acc, input mcand, input window, input shamt, output sum);
endinterface : bmac_step_if

// ### verilog/bmac_booth_step.sv
// One radix-4 Booth step: adds 0, +-1 or +-2 times the shifted multiplicand.
// Assumes the caller supplies the three-bit window and the weight shift.
`timescale 1ns/10ps
module bmac_booth_step (
  // Operand and result carrier.
  bmac_step_if.step bus
);

  logic [31:0] weighted;
  logic [31:0] sum_next;

  // Shift the multiplicand to the weight of the current bit pair.
  assign weighted = bus.mcand << bus.shamt;

  // Recode the window and add the chosen multiple; only the low word is kept.
  always_comb begin
    sum_next = bus.acc;
    unique case (bus.window)
      3'h0, 3'h7: sum_next = bus.acc;
      3'h1, 3'h2: sum_next = bus.acc + weighted;
      3'h3: sum_next = bus.acc + {weighted[30:0], 1'b0};
      3'h4: sum_next = bus.acc - {weighted[30:0], 1'b0};
      3'h5, 3'h6: sum_next = bus.acc - weighted;
    endcase
  end

  assign bus.sum = sum_next;

endmodule : bmac_booth_step

// ### verilog/bmac_unit.sv
// Multiply and multiply-accumulate datapath of the core, Booth radix-4.
// Assumes the decoder and register file sit on the same clock, present
// operand values and register indices with a one-cycle start pulse, and
// hold further issue while busy is high.
//
// Overview of operation
// - Booth recoding, two multiplier bits per step.
// - Write only low 32 product bits.
// - Plain multiply ignores addend; software zeroes field.
// - Accumulate form adds addend to product.
// - Same bits for signed and unsigned operands.
// - Destination holds partials; multiplicand reread each step.
// - Destination equals multiplicand: plain gives zero.
// - Program counter destination: no register write.
// - Other aliasing, including destination/addend/multiplier, works.
// - Flags change only when flag-update requested.
// - Negative copies bit 31; zero when result zero.
// - Overflow kept; carry loaded with arbitrary value.
// - Multiplier from counter: address plus eight, no status.
// - Addend from counter: address plus eight, with status.
// - Multiplicand from counter: address plus twelve, with status.
`timescale 1ns/10ps
module bmac_unit (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Request from the instruction decoder.
  input wire logic start,
  input wire logic product_accumulate_op,
  input wire logic set_flags,
  input wire logic [3:0] dest_idx,
  input wire logic [3:0] multiplicand_idx,
  input wire logic [3:0] multiplier_idx,
  input wire logic [3:0] addend_idx,
  // Operand values from the register file and the program counter.
  input wire logic [31:0] multiplicand_reg,
  input wire logic [31:0] multiplier_reg,
  input wire logic [31:0] addend_reg,
  input wire logic [31:0] instr_addr,
  input wire logic [31:0] processor_status_bits,
  // Sequencing answer to the pipeline.
  output logic busy,
  output logic done,
  // Result write to the register file.
  output logic result_wr_en,
  output logic [3:0] result_wr_idx,
  output logic [31:0] result_data,
  // Status flag write.
  output logic flags_wr_en,
  output logic flag_n,
  output logic flag_z,
  output logic flag_c,
  output logic flag_v
);

  // Sequencer and datapath state.
  bmac_pkg::bmac_state_t state_reg, state_next;
  logic [bmac_pkg::STEP_CNT_W-1:0] step_reg, step_next;
  logic [31:0] acc_reg, acc_next;
  logic [31:0] mcand_reg, mcand_next;
  logic [32:0] mplier_reg, mplier_next;
  logic alias_reg, alias_next;
  logic flags_req_reg, flags_req_next;
  logic v_keep_reg, v_keep_next;
  logic [3:0] dest_reg, dest_next;

  // Registered outputs.
  logic busy_next;
  logic done_next;
  logic result_wr_en_next;
  logic [3:0] result_wr_idx_next;
  logic [31:0] result_data_next;
  logic flags_wr_en_next;
  logic flag_n_next;
  logic flag_z_next;
  logic flag_c_next;
  logic flag_v_next;

  // Operand values after program counter substitution.
  logic [31:0] status_part;
  logic [31:0] pc_plus8;
  logic [31:0] pc_plus12;
  logic [31:0] mcand_in;
  logic [31:0] mplier_in;
  logic [31:0] addend_in;
  logic [31:0] step_sum;

  // Booth step carrier.
  bmac_step_if step_bus ();

  // Program counter views as each operand slot sees it after prefetch.
  assign status_part = processor_status_bits & bmac_pkg::STATUS_FIELD_MASK;
  assign pc_plus8 = (instr_addr + bmac_pkg::MULTIPLIER_PC_OFFSET) & bmac_pkg::PC_FIELD_MASK;
  assign pc_plus12 = (instr_addr + bmac_pkg::MULTIPLICAND_PC_OFFSET)
                     & bmac_pkg::PC_FIELD_MASK;

  // Substitute the program counter register where it is named as an operand.
  always_comb begin
    mplier_in = multiplier_reg;
    addend_in = addend_reg;
    mcand_in = multiplicand_reg;
    if (multiplier_idx == bmac_pkg::PC_REG_IDX) begin
      mplier_in = pc_plus8;
    end
    if (addend_idx == bmac_pkg::PC_REG_IDX) begin
      addend_in = ((instr_addr + bmac_pkg::ADDEND_PC_OFFSET) & bmac_pkg::PC_FIELD_MASK)
                  | status_part;
    end
    if (multiplicand_idx == bmac_pkg::PC_REG_IDX) begin
      mcand_in = pc_plus12 | status_part;
    end
  end

  // Feed the Booth step. With destination and multiplicand aliased, the
  // multiplicand read each step is the partial sum itself, as in a core
  // that keeps partials in the destination register.
  assign step_bus.acc = acc_reg;
  assign step_bus.mcand = alias_reg ? acc_reg : mcand_reg;
  assign step_bus.window = mplier_reg[2:0];
  assign step_bus.shamt = {step_reg, 1'b0};
  assign step_sum = step_bus.sum;

  bmac_booth_step u_step (
    .bus(step_bus)
  );

  // Next-state logic of the sequencer, datapath and outputs.
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    acc_next = acc_reg;
    mcand_next = mcand_reg;
    mplier_next = mplier_reg;
    alias_next = alias_reg;
    flags_req_next = flags_req_reg;
    v_keep_next = v_keep_reg;
    dest_next = dest_reg;
    busy_next = busy;
    done_next = 1'b0;
    result_wr_en_next = 1'b0;
    result_wr_idx_next = result_wr_idx;
    result_data_next = result_data;
    flags_wr_en_next = 1'b0;
    flag_n_next = flag_n;
    flag_z_next = flag_z;
    flag_c_next = flag_c;
    flag_v_next = flag_v;
    unique case (state_reg)
      bmac_pkg::BMAC_IDLE: begin
        if (start) begin
          // Capture every operand up front so any aliasing among
          // destination, addend and multiplier cannot disturb the result.
          state_next = bmac_pkg::BMAC_RUN;
          step_next = bmac_pkg::STEP_RESET;
          acc_next = product_accumulate_op ? addend_in : bmac_pkg::DATA_RESET;
          mcand_next = mcand_in;
          mplier_next = {mplier_in, 1'b0};
          alias_next = (dest_idx == multiplicand_idx);
          flags_req_next = set_flags;
          v_keep_next = processor_status_bits[bmac_pkg::FLAG_V_POS];
          dest_next = dest_idx;
          busy_next = 1'b1;
        end
      end
      bmac_pkg::BMAC_RUN: begin
        // One bit pair per cycle; the low word is the same for signed and
        // unsigned operands, so no sign mode exists.
        acc_next = step_sum;
        mplier_next = {2'b00, mplier_reg[32:2]};
        step_next = step_reg + 4'h1;
        if (step_reg == bmac_pkg::LAST_STEP) begin
          state_next = bmac_pkg::BMAC_IDLE;
          busy_next = 1'b0;
          done_next = 1'b1;
          result_wr_en_next = (dest_reg != bmac_pkg::PC_REG_IDX);
          result_wr_idx_next = dest_reg;
          result_data_next = step_sum;
          if (flags_req_reg) begin
            flags_wr_en_next = 1'b1;
            flag_n_next = step_sum[bmac_pkg::RESULT_SIGN_POS];
            flag_z_next = (step_sum == bmac_pkg::DATA_RESET);
            flag_c_next = mcand_reg[0];
            flag_v_next = v_keep_reg;
          end
        end
      end
    endcase
  end

  // Register the sequencer and datapath state.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= bmac_pkg::BMAC_IDLE;
      step_reg <= bmac_pkg::STEP_RESET;
      acc_reg <= bmac_pkg::DATA_RESET;
      mcand_reg <= bmac_pkg::DATA_RESET;
      mplier_reg <= 33'h000000000;
      alias_reg <= 1'b0;
      flags_req_reg <= 1'b0;
      v_keep_reg <= 1'b0;
      dest_reg <= bmac_pkg::IDX_RESET;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      acc_reg <= acc_next;
      mcand_reg <= mcand_next;
      mplier_reg <= mplier_next;
      alias_reg <= alias_next;
      flags_req_reg <= flags_req_next;
      v_keep_reg <= v_keep_next;
      dest_reg <= dest_next;
    end
  end

  // Register the outputs so each comes straight from a flip-flop.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      result_wr_en <= 1'b0;
      result_wr_idx <= bmac_pkg::IDX_RESET;
      result_data <= bmac_pkg::DATA_RESET;
      flags_wr_en <= 1'b0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      flag_c <= 1'b0;
      flag_v <= 1'b0;
    end else begin
      busy <= busy_next;
      done <= done_next;
      result_wr_en <= result_wr_en_next;
      result_wr_idx <= result_wr_idx_next;
      result_data <= result_data_next;
      flags_wr_en <= flags_wr_en_next;
      flag_n <= flag_n_next;
      flag_z <= flag_z_next;
      flag_c <= flag_c_next;
      flag_v <= flag_v_next;
    end
  end

endmodule : bmac_unit

// ### tb/bmac_checker.sv
// Port assertions for the multiply-accumulate unit.
// Assumes one core clock and an asynchronous active-high reset.
`timescale 1ns/10ps
module bmac_checker (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Request and answer.
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic result_wr_en,
  input wire logic [3:0] result_wr_idx,
  input wire logic [31:0] result_data,
  input wire logic [31:0] processor_status_bits,
  // Flags.
  input wire logic flags_wr_en,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic flag_c,
  input wire logic flag_v
);
  // All checks share the core clock and its reset.
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // A taken request and the stall steps after it.
  sequence s_take;
    start && !busy;
  endsequence
  sequence s_stall;
    (busy && !done)[*8] ##1 (busy && !done)[*8];
  endsequence
  // Properties on the sequence and the writes.
  property p_stall;
    s_take |=> s_stall ##1 (done && !busy);
  endproperty
  property p_pulse;
    done |=> !done && !result_wr_en && !flags_wr_en;
  endproperty
  property p_pc_dest;
    done |-> (result_wr_en == (result_wr_idx != 4'hf));
  endproperty
  property p_wr_done;
    result_wr_en |-> done;
  endproperty
  property p_flag_done;
    flags_wr_en |-> done;
  endproperty
  property p_nz;
    flags_wr_en && result_wr_en |-> flag_n == result_data[31] && flag_z == (result_data == 32'h0);
  endproperty
  property p_keep;
    !flags_wr_en |-> $stable({flag_n, flag_z, flag_c, flag_v});
  endproperty
  property p_v;
    flags_wr_en |-> flag_v == $past(processor_status_bits[28], 17);
  endproperty
  a_stall: assert property (p_stall) else $error("stall length wrong");
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  a_pc_dest: assert property (p_pc_dest) else $error("write enable wrong");
  a_wr_done: assert property (p_wr_done) else $error("stray write");
  a_flag_done: assert property (p_flag_done) else $error("stray flag write");
  a_nz: assert property (p_nz) else $error("n or z wrong");
  a_keep: assert property (p_keep) else $error("flags moved");
  a_v: assert property (p_v) else $error("v not kept");
endmodule : bmac_checker

bind bmac_unit bmac_checker i_chk (.clock, .reset, .start, .busy, .done, .result_wr_en,
  .result_wr_idx, .result_data, .processor_status_bits, .flags_wr_en, .flag_n, .flag_z,
  .flag_c, .flag_v);

// ### tb/bmac_regfile_model.sv
// Register file seen by the unit, read by index.
// Assumes the bench preloads regs; slot 15 holds junk the unit must ignore.
`timescale 1ns/10ps
module bmac_regfile_model (
  // Operand selects.
  input wire logic [3:0] mcand_sel,
  input wire logic [3:0] mplier_sel,
  input wire logic [3:0] addend_sel,
  // Operand values.
  output logic [31:0] mcand_val,
  output logic [31:0] mplier_val,
  output logic [31:0] addend_val
);
  logic [31:0] regs [16];
  // Plain reads; values stand as long as the selects stand.
  always_comb begin
    mcand_val = regs[mcand_sel];
    mplier_val = regs[mplier_sel];
    addend_val = regs[addend_sel];
  end
endmodule : bmac_regfile_model

// ### tb/bmac_unit_tb.sv
// Self-checking bench for the multiply-accumulate unit.
// Assumes the checker is bound in and the model supplies operands.
`timescale 1ns/10ps
module bmac_unit_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic op = 1'b0;
  logic sf = 1'b0;
  logic [3:0] d = 4'h0, m = 4'h0, s = 4'h0, a = 4'h0, rd, rm;
  logic [31:0] ia = 32'h0, st = 32'h0, vm, vs, va, wdata;
  logic busy, done, wen, fen, fn, fz, fc, fv;
  logic [3:0] widx;
  logic [31:0] shadow [16];
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Core clock, 8 ns period.
  always #4 clock = ~clock;

  bmac_regfile_model i_rf (.mcand_sel(m), .mplier_sel(s), .addend_sel(a), .mcand_val(vm),
    .mplier_val(vs), .addend_val(va));
  bmac_unit i_dut (.clock(clock), .reset(reset), .start(start), .product_accumulate_op(op),
    .set_flags(sf), .dest_idx(d), .multiplicand_idx(m), .multiplier_idx(s),
    .addend_idx(a), .multiplicand_reg(vm), .multiplier_reg(vs), .addend_reg(va),
    .instr_addr(ia), .processor_status_bits(st), .busy(busy), .done(done),
    .result_wr_en(wen), .result_wr_idx(widx), .result_data(wdata), .flags_wr_en(fen),
    .flag_n(fn), .flag_z(fz), .flag_c(fc), .flag_v(fv));

  // Compares one value and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Operand seen for a slot; slot 15 gives the counter plus an offset.
  function automatic logic [31:0] opnd(input logic [3:0] i, input logic [31:0] off,
      input logic with_st);
    if (i != 4'hf) return shadow[i];
    return ((ia + off) & 32'h03fffffc) | (with_st ? (st & 32'hfc000003) : 32'h0);
  endfunction : opnd

  // One request, a refused second start while busy, then the answer.
  task automatic run(input logic o, input logic f, input logic [3:0] td, tm, ts, tn);
    logic [31:0] exp;
    int n;
    @(posedge clock);
    start <= 1'b1;
    op <= o;
    sf <= f;
    d <= td;
    m <= tm;
    s <= ts;
    a <= tn;
    ia <= $urandom;
    st <= $urandom;
    @(posedge clock);
    d <= ~td;
    exp = opnd(tm, 32'hc, 1'b1) * opnd(ts, 32'h8, 1'b0) + (o ? opnd(tn, 32'h8, 1'b1) : 32'h0);
    if (td == tm) exp = 32'h0;
    @(posedge clock);
    start <= 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 30) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n, 16);
    check(wen, td != 4'hf);
    if (td != 4'hf) begin
      check(wdata, exp);
      check(widx, td);
    end
    check(fen, f);
    if (f) begin
      check(fn, exp[31]);
      check(fz, exp == 32'h0);
      check(fv, st[28]);
    end
  endtask : run

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Errors: %0d, checks: %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Cuts a hung run short.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      stop_test();
    end
  end

  // Corner cases first, then random requests.
  initial begin
    void'($urandom(28849));
    for (int k = 0; k < 16; k++) shadow[k] = $urandom;
    shadow[10] = 32'h0;
    shadow[11] = 32'hffffffff;
    shadow[12] = 32'h80000000;
    for (int k = 0; k < 16; k++) i_rf.regs[k] = shadow[k];
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    run(1'b0, 1'b1, 4'h1, 4'h1, 4'h2, 4'h0);
    run(1'b1, 1'b1, 4'hf, 4'h2, 4'h3, 4'h4);
    run(1'b0, 1'b1, 4'h5, 4'hf, 4'h6, 4'h0);
    run(1'b1, 1'b0, 4'h5, 4'h6, 4'hf, 4'h7);
    run(1'b1, 1'b1, 4'h7, 4'h8, 4'h9, 4'hf);
    run(1'b1, 1'b1, 4'h9, 4'h3, 4'h9, 4'h9);
    run(1'b1, 1'b1, 4'h3, 4'hb, 4'hc, 4'hb);
    run(1'b0, 1'b1, 4'h4, 4'hb, 4'ha, 4'h0);
    for (int k = 0; k < 50; k++) begin
      rd = 4'($urandom);
      rm = 4'($urandom);
      if (rm == rd) rm = rd ^ 4'h1;
      run(1'($urandom), 1'($urandom), rd, rm, 4'($urandom), 4'($urandom));
    end
    stop_test();
  end
endmodule : bmac_unit_tb
